/* File: paz_far_model.sv */
// Far side of the sequencer: phase processor and detector digitizer.
// Assumes one command at a time; answers alternate prompt and slow.
`timescale 1ns/1ps
`default_nettype none
module paz_far_model
  import paz_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic sc_in,
  input wire paz_pkg::paz_cmd_t cmd_in,
  input wire logic [15:0] err_in,
  input wire logic glitch_in,
  output logic flag_out,
  output logic [15:0] reading_out
);
  logic [3:0] cnt;
  logic slow;
  logic conv;
  logic minus;
  logic [15:0] ofs;
  logic [7:0] nconv;
  logic [15:0] e;
  logic [15:0] val;

  // Detector output follows the residual error, sign set by the phase
  assign e = err_in - ofs;
  assign val = (minus ? -e : e) + ((glitch_in && nconv == 8'h1) ? 16'h0100 : 16'h0000);

  // Drop the flag on each pulse, raise it after the answer delay
  always @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      flag_out <= 1'b0;
      reading_out <= 16'h5a5a;
      {cnt, slow, conv, minus, ofs, nconv} <= '0;
    end
    else if (sc_in)
    begin
      flag_out <= 1'b0;
      reading_out <= ~reading_out; // Released data never holds its value
      slow <= ~slow;
      cnt <= slow ? 4'h9 : 4'h3;
      conv <= (cmd_in.kind == PAZ_CMD_CONVERT);
      if (cmd_in.kind == PAZ_CMD_OFFSET)
        ofs <= cmd_in.data[15:0];
      if (cmd_in.kind == PAZ_CMD_PHASE)
        minus <= cmd_in.data[31];
    end
    else if (cnt == 4'h1)
    begin
      flag_out <= 1'b1;
      cnt <= 4'h0;
      if (conv)
        reading_out <= val;
      if (conv)
        nconv <= nconv + 8'h1;
    end
    else if (cnt != 4'h0)
      cnt <= cnt - 4'h1;
endmodule : paz_far_model
`default_nettype wire

/* File: paz_pkg.sv */
// Constants, command carrier and state codes of the auto-zero sequencer.
// Assumes a 250 MHz core clock; angles are in units of 0.1 millidegree.
package paz_pkg;

  // Clock rate and settle time
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned SETTLE_MS = 660;
  localparam int unsigned SETTLE_CYC = SETTLE_MS * 1000 * CLK_MHZ;

  // Angles in 0.1 millidegree units
  localparam logic [31:0] PH_PLUS90 = 32'h000d_bba0;
  localparam logic [31:0] PH_MINUS90 = 32'hfff2_4460;
  localparam logic [31:0] PH_ZERO = 32'h0000_0000;
  localparam logic [31:0] AZ_FREQ_HZ = 32'h0000_1000;
  localparam logic [31:0] SW_NORMAL = 32'h0000_0000;
  localparam logic [31:0] SW_REVERSE = 32'h0000_0001;

  // Register indices on the address port
  localparam int AW = 4;
  localparam logic [AW-1:0] REG_CTRL = 4'h0;
  localparam logic [AW-1:0] REG_STATUS = 4'h1;
  localparam logic [AW-1:0] REG_NORMAL_CAL_FACTOR = 4'h2;
  localparam logic [AW-1:0] REG_REVERSE_CAL_FACTOR = 4'h3;
  localparam logic [AW-1:0] REG_READ_TOL = 4'h4;
  localparam logic [AW-1:0] REG_FINAL_TOL = 4'h5;
  localparam logic [AW-1:0] REG_MAX_ITER = 4'h6;
  localparam logic [AW-1:0] REG_RANGE_OFS = 4'h7;
  localparam logic [AW-1:0] REG_ORIG_FREQ = 4'h8;
  localparam logic [AW-1:0] REG_ATTEN_CORR = 4'h9;
  localparam logic [AW-1:0] REG_FREQ_ADJ = 4'ha;
  localparam logic [AW-1:0] REG_CORR_ACC = 4'hb;
  localparam logic [AW-1:0] REG_ITER = 4'hc;

  // Control and status bit positions
  localparam int CTRL_START = 0;
  localparam int CTRL_CAL_ACK = 1;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_ERROR = 2;
  localparam int ST_CAL_REQ = 3;

  // Reset values
  localparam logic [15:0] CAL_RST = 16'h0100;
  localparam logic [15:0] READ_TOL_RST = 16'h0010;
  localparam logic [31:0] FINAL_TOL_RST = 32'h0000_0005;
  localparam logic [7:0] MAX_ITER_RST = 8'h10;

  // Commands to the phase processor and digitizer
  typedef enum logic [2:0] {
    PAZ_CMD_PHASE = 3'h0,
    PAZ_CMD_OFFSET = 3'h1,
    PAZ_CMD_FREQ = 3'h2,
    PAZ_CMD_SWITCH = 3'h3,
    PAZ_CMD_CONVERT = 3'h4
  } paz_cmd_kind_t;

  typedef struct packed {
    paz_cmd_kind_t kind;
    logic [31:0] data;
  } paz_cmd_t;

  typedef enum logic [11:0] {
    S_IDLE = 12'h001,
    S_FACTOR = 12'h002,
    S_CAL_WAIT = 12'h004,
    S_SETUP = 12'h008,
    S_COND_SW = 12'h010,
    S_COND_PH = 12'h020,
    S_SETTLE = 12'h040,
    S_READ = 12'h080,
    S_READ_EVAL = 12'h100,
    S_PASS_END = 12'h200,
    S_FINISH = 12'h400,
    S_SEND_WAIT = 12'h800
  } paz_state_t;

endpackage : paz_pkg

/* File: paz_sequencer.sv */
// Auto-zero sequencer: four-condition phase detector null search.
// Assumes a processor/digitizer that answers each set-control pulse with a
// flag rising edge, and a result word held stable while the flag is high.
`timescale 1ns/1ps
`default_nettype none

module paz_sequencer #(
  parameter int unsigned SETTLE_CYCLES = paz_pkg::SETTLE_CYC
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [paz_pkg::AW-1:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic flag_in,
  input wire logic [15:0] reading_in,
  output logic sc_pulse_out,
  output paz_pkg::paz_cmd_t cmd_out
);
  import paz_pkg::*;

  paz_state_t state;
  paz_state_t ret_state;
  logic [2:0] flag_sync;
  logic flag_stable;
  logic [15:0] normal_cal_factor;
  logic [15:0] reverse_cal_factor;
  logic [15:0] read_tol;
  logic [31:0] final_tol;
  logic [7:0] max_iter;
  logic [31:0] range_ofs;
  logic [31:0] orig_freq;
  logic [31:0] atten_corr;
  logic [31:0] freq_adj;
  logic [31:0] correction_accumulator;
  logic [31:0] partial_correction_store;
  logic [7:0] iter;
  logic [7:0] retries;
  logic [1:0] cond;
  logic [2:0] nread;
  logic [1:0] fin_step;
  logic [17:0] read_sum;
  logic [15:0] prev_read;
  logic [31:0] settle_cnt;
  logic recal_done;
  logic busy;
  logic done;
  logic error;
  logic cal_req;

  // Absolute value of a signed word
  function automatic logic [31:0] abs32(input logic [31:0] v);
    abs32 = v[31] ? 32'(-v) : v;
  endfunction : abs32

  // Sign-extend a 16-bit reading
  function automatic logic [31:0] sx16(input logic [15:0] v);
    sx16 = {{16{v[15]}}, v};
  endfunction : sx16

  // Positive when tolerance exceeds the absolute difference
  function automatic logic convergence_check(input logic [31:0] diff,
                                             input logic [31:0] tol);
    convergence_check = tol > abs32(diff);
  endfunction : convergence_check

  // Condition table: plus angle for conditions 0 and 3, reversed for 2 and 3
  wire cond_plus = (cond == 2'd0) || (cond == 2'd3);
  wire cond_rev = cond[1];

  // Flag crosses in from the far side; counts once stages two and three agree
  wire flag_rise = flag_sync[1] & flag_sync[2] & ~flag_stable;
  wire flag_fall = ~flag_sync[1] & ~flag_sync[2] & flag_stable;

  // Register decode
  wire wr_ctrl = wr_in && (addr_in == REG_CTRL);
  wire start_req = wr_ctrl && wdata_in[CTRL_START];
  wire cal_ack = wr_ctrl && wdata_in[CTRL_CAL_ACK];
  wire cfg_wr = wr_in && !busy;

  // Factor comparison: larger over smaller by more than 25 percent
  wire swap_need = reverse_cal_factor > normal_cal_factor;
  wire [15:0] big_f = swap_need ? reverse_cal_factor : normal_cal_factor;
  wire [15:0] small_f = swap_need ? normal_cal_factor : reverse_cal_factor;
  wire [19:0] big_x4 = {2'b00, big_f, 2'b00};
  wire [19:0] small_x5 = {2'b00, small_f, 2'b00} + {4'h0, small_f};
  wire ratio_bad = big_x4 > small_x5;

  // Reading checks and condition average scaled by the larger factor
  wire [31:0] new_read = sx16(reading_in);
  wire [31:0] read_diff = new_read - sx16(prev_read);
  wire read_bad = (nread != 3'd0) &&
                  (abs32(read_diff) > {16'h0000, read_tol});
  wire [17:0] next_sum = read_sum + {{2{reading_in[15]}}, reading_in};
  // Signed shift, so a negative sum stays negative after the divide by four
  wire [31:0] cond_avg = $signed({{14{next_sum[17]}}, next_sum}) >>> 2;
  wire [31:0] cal_div = (normal_cal_factor == 16'h0000) ? 32'h0000_0001 :
                        {16'h0000, normal_cal_factor};
  wire signed [31:0] scaled = $signed(cond_avg) / $signed(cal_div);
  wire [31:0] next_partial = cond_plus ?
                             partial_correction_store + 32'(scaled) :
                             partial_correction_store - 32'(scaled);
  wire [31:0] pass_avg = $signed(partial_correction_store) >>> 2;
  wire [31:0] next_acc = correction_accumulator + pass_avg;

  // Register read mux, answered one cycle after the strobe
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (addr_in)
      REG_STATUS: rd_mux = {28'h0, cal_req, error, done, busy};
      REG_NORMAL_CAL_FACTOR: rd_mux = {16'h0000, normal_cal_factor};
      REG_REVERSE_CAL_FACTOR: rd_mux = {16'h0000, reverse_cal_factor};
      REG_READ_TOL: rd_mux = {16'h0000, read_tol};
      REG_FINAL_TOL: rd_mux = final_tol;
      REG_MAX_ITER: rd_mux = {24'h000000, max_iter};
      REG_RANGE_OFS: rd_mux = range_ofs;
      REG_ORIG_FREQ: rd_mux = orig_freq;
      REG_ATTEN_CORR: rd_mux = atten_corr;
      REG_FREQ_ADJ: rd_mux = freq_adj;
      REG_CORR_ACC: rd_mux = correction_accumulator;
      REG_ITER: rd_mux = {24'h000000, iter};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data register
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rdata_out <= 32'h0000_0000;
    else
      rdata_out <= rd_in ? rd_mux : 32'h0000_0000;
  end

  // Three-stage flag synchroniser and its settled level
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      flag_sync <= 3'b000;
      flag_stable <= 1'b0;
    end
    else
    begin
      flag_sync <= {flag_sync[1:0], flag_in};
      if (flag_rise || flag_fall)
        flag_stable <= flag_sync[2];
    end
  end

  // Configuration registers; frozen while a run is in progress
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      read_tol <= READ_TOL_RST;
      final_tol <= FINAL_TOL_RST;
      max_iter <= MAX_ITER_RST;
      range_ofs <= 32'h0000_0000;
      orig_freq <= 32'h0000_0000;
      atten_corr <= 32'h0000_0000;
      freq_adj <= 32'h0000_0000;
    end
    else if (cfg_wr)
    begin
      unique case (addr_in)
        REG_READ_TOL: read_tol <= wdata_in[15:0];
        REG_FINAL_TOL: final_tol <= wdata_in;
        REG_MAX_ITER: max_iter <= wdata_in[7:0];
        REG_RANGE_OFS: range_ofs <= wdata_in;
        REG_ORIG_FREQ: orig_freq <= wdata_in;
        REG_ATTEN_CORR: atten_corr <= wdata_in;
        REG_FREQ_ADJ: freq_adj <= wdata_in;
        default: ;
      endcase
    end
  end

  // Main sequencer; every command goes out through the send-wait state
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state <= S_IDLE;
      ret_state <= S_IDLE;
      sc_pulse_out <= 1'b0;
      cmd_out <= '{kind: PAZ_CMD_PHASE, data: 32'h0000_0000};
      normal_cal_factor <= CAL_RST;
      reverse_cal_factor <= CAL_RST;
      correction_accumulator <= 32'h0000_0000;
      partial_correction_store <= 32'h0000_0000;
      iter <= 8'h00;
      retries <= 8'h00;
      cond <= 2'd0;
      nread <= 3'd0;
      fin_step <= 2'd0;
      read_sum <= 18'h00000;
      prev_read <= 16'h0000;
      settle_cnt <= 32'h0000_0000;
      recal_done <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      error <= 1'b0;
      cal_req <= 1'b0;
    end
    else
    begin
      sc_pulse_out <= 1'b0;
      if (!busy && wr_in && addr_in == REG_NORMAL_CAL_FACTOR)
        normal_cal_factor <= wdata_in[15:0];
      if (!busy && wr_in && addr_in == REG_REVERSE_CAL_FACTOR)
        reverse_cal_factor <= wdata_in[15:0];
      unique case (state)
        S_IDLE:
        begin
          if (start_req)
          begin
            busy <= 1'b1;
            done <= 1'b0;
            error <= 1'b0;
            recal_done <= 1'b0;
            correction_accumulator <= 32'h0000_0000;
            iter <= 8'h00;
            state <= S_FACTOR;
          end
        end
        S_FACTOR:
        begin
          normal_cal_factor <= big_f;
          reverse_cal_factor <= small_f;
          if (ratio_bad && !recal_done)
          begin
            cal_req <= 1'b1;
            state <= S_CAL_WAIT;
          end
          else
            state <= S_SETUP;
        end
        S_CAL_WAIT:
        begin
          // Software remeasures and rewrites the factors, then acknowledges
          if (wr_in && addr_in == REG_NORMAL_CAL_FACTOR)
            normal_cal_factor <= wdata_in[15:0];
          if (wr_in && addr_in == REG_REVERSE_CAL_FACTOR)
            reverse_cal_factor <= wdata_in[15:0];
          if (cal_ack)
          begin
            cal_req <= 1'b0;
            recal_done <= 1'b1;
            state <= S_FACTOR;
          end
        end
        S_SETUP:
        begin
          cmd_out <= '{kind: PAZ_CMD_FREQ, data: AZ_FREQ_HZ};
          sc_pulse_out <= 1'b1;
          cond <= 2'd0;
          partial_correction_store <= 32'h0000_0000;
          ret_state <= S_COND_SW;
          state <= S_SEND_WAIT;
        end
        S_COND_SW:
        begin
          cmd_out <= '{kind: PAZ_CMD_SWITCH,
                       data: cond_rev ? SW_REVERSE : SW_NORMAL};
          sc_pulse_out <= 1'b1;
          ret_state <= S_COND_PH;
          state <= S_SEND_WAIT;
        end
        S_COND_PH:
        begin
          cmd_out <= '{kind: PAZ_CMD_PHASE,
                       data: cond_plus ? PH_PLUS90 : PH_MINUS90};
          sc_pulse_out <= 1'b1;
          settle_cnt <= 32'h0000_0000;
          nread <= 3'd0;
          retries <= 8'h00;
          read_sum <= 18'h00000;
          ret_state <= S_SETTLE;
          state <= S_SEND_WAIT;
        end
        S_SETTLE:
        begin
          // Long settle counter; the parameter lets simulation shorten it
          if (settle_cnt >= SETTLE_CYCLES - 1)
            state <= S_READ;
          else
            settle_cnt <= settle_cnt + 32'h0000_0001;
        end
        S_READ:
        begin
          cmd_out <= '{kind: PAZ_CMD_CONVERT, data: 32'h0000_0000};
          sc_pulse_out <= 1'b1;
          ret_state <= S_READ_EVAL;
          state <= S_SEND_WAIT;
        end
        S_READ_EVAL:
        begin
          if (read_bad)
          begin
            // Detector still moving: retake, but never forever
            prev_read <= reading_in;
            retries <= retries + 8'h01;
            if (retries + 8'h01 >= max_iter)
            begin
              error <= 1'b1;
              state <= S_FINISH;
              fin_step <= 2'd1;
            end
            else
              state <= S_READ;
          end
          else if (nread == 3'd3)
          begin
            partial_correction_store <= next_partial;
            if (cond == 2'd3)
              state <= S_PASS_END;
            else
            begin
              cond <= cond + 2'd1;
              state <= S_COND_SW;
            end
          end
          else
          begin
            prev_read <= reading_in;
            read_sum <= next_sum;
            nread <= nread + 3'd1;
            state <= S_READ;
          end
        end
        S_PASS_END:
        begin
          correction_accumulator <= next_acc;
          cmd_out <= '{kind: PAZ_CMD_OFFSET,
                       data: next_acc + range_ofs};
          sc_pulse_out <= 1'b1;
          iter <= iter + 8'h01;
          if (convergence_check(pass_avg, final_tol))
          begin
            fin_step <= 2'd0;
            ret_state <= S_FINISH;
          end
          else if (iter + 8'h01 >= max_iter)
          begin
            error <= 1'b1;
            fin_step <= 2'd1;
            ret_state <= S_FINISH;
          end
          else
            ret_state <= S_SETUP;
          state <= S_SEND_WAIT;
        end
        S_FINISH:
        begin
          sc_pulse_out <= 1'b1;
          fin_step <= fin_step + 2'd1;
          ret_state <= (fin_step == 2'd3) ? S_IDLE : S_FINISH;
          state <= S_SEND_WAIT;
          unique case (fin_step)
            2'd0:
            begin
              correction_accumulator <= correction_accumulator +
                                        atten_corr + freq_adj;
              cmd_out <= '{kind: PAZ_CMD_OFFSET,
                           data: correction_accumulator + atten_corr +
                                 freq_adj + range_ofs};
            end
            2'd1: cmd_out <= '{kind: PAZ_CMD_FREQ, data: orig_freq};
            2'd2: cmd_out <= '{kind: PAZ_CMD_SWITCH, data: SW_NORMAL};
            2'd3: cmd_out <= '{kind: PAZ_CMD_PHASE, data: PH_ZERO};
          endcase
        end
        S_SEND_WAIT:
        begin
          // Hold the command until the far side flags completion
          if (flag_rise)
          begin
            state <= ret_state;
            if (ret_state == S_IDLE)
            begin
              busy <= 1'b0;
              done <= 1'b1;
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Every pass sends four switch and four phase steps before its offset
  logic [3:0] pass_steps;
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      pass_steps <= 4'h0;
    else if (state == S_SETUP)
      pass_steps <= 4'h0;
    else if (state == S_COND_PH)
      pass_steps <= pass_steps + 4'h1;
  end

  pass_four_conds_a: assert property (@(posedge core_clk_in)
    disable iff (!rst_n_in)
    state == S_PASS_END |-> pass_steps == 4'h4)
    else $error("offset sent before four conditions");

  phase_sign_a: assert property (@(posedge core_clk_in)
    disable iff (!rst_n_in)
    sc_pulse_out && cmd_out.kind == PAZ_CMD_PHASE && busy && !done &&
    state == S_SEND_WAIT && ret_state == S_SETTLE |->
    cmd_out.data == ((pass_steps == 4'h1 || pass_steps == 4'h4) ?
                     PH_PLUS90 : PH_MINUS90))
    else $error("wrong phase for condition");

  switch_order_a: assert property (@(posedge core_clk_in)
    disable iff (!rst_n_in)
    sc_pulse_out && state == S_SEND_WAIT && ret_state == S_COND_PH |->
    cmd_out.kind == PAZ_CMD_SWITCH &&
    cmd_out.data == (pass_steps[1] ? SW_REVERSE : SW_NORMAL))
    else $error("wrong switch for condition");

  settle_wait_a: assert property (@(posedge core_clk_in)
    disable iff (!rst_n_in)
    $rose(state == S_READ) && $past(state) == S_SETTLE |->
    $past(settle_cnt) >= SETTLE_CYCLES - 1)
    else $error("reading started before settle time");

  sc_single_a: assert property (@(posedge core_clk_in)
    disable iff (!rst_n_in)
    sc_pulse_out |=> !sc_pulse_out && state == S_SEND_WAIT)
    else $error("set-control not a single pulse");

  flag_return_a: assert property (@(posedge core_clk_in)
    disable iff (!rst_n_in)
    state == S_SEND_WAIT && flag_rise |=> state == $past(ret_state))
    else $error("flag did not release the wait");

  factor_order_a: assert property (@(posedge core_clk_in)
    disable iff (!rst_n_in)
    $past(state) == S_FACTOR && state == S_SETUP |->
    normal_cal_factor >= reverse_cal_factor)
    else $error("normal factor not the larger");

  recal_once_a: assert property (@(posedge core_clk_in)
    disable iff (!rst_n_in)
    state == S_CAL_WAIT |-> !recal_done && cal_req)
    else $error("redetermination requested twice");

  acc_update_a: assert property (@(posedge core_clk_in)
    disable iff (!rst_n_in)
    state == S_PASS_END |=> cmd_out.kind == PAZ_CMD_OFFSET &&
    cmd_out.data == correction_accumulator + range_ofs)
    else $error("offset differs from accumulator plus range");

  iter_limit_a: assert property (@(posedge core_clk_in)
    disable iff (!rst_n_in)
    busy && max_iter != 8'h00 |-> iter <= max_iter)
    else $error("iteration limit overrun");

endmodule : paz_sequencer

`default_nettype wire

/* File: tb_paz_sequencer.sv */
// Testbench for the auto-zero sequencer: bus tasks and command log checks.
// Assumes the far model answers every set-control pulse.
`timescale 1ns/1ps
`default_nettype none
module tb_paz_sequencer;
  import paz_pkg::*;
  localparam int unsigned SETTLE = 20;
  logic clk, rst_n, wr, rd, flag, sc, glitch;
  logic [AW-1:0] addr;
  logic [31:0] wdata, rdata, d, sw;
  logic [15:0] reading, err;
  paz_cmd_t cmd;
  paz_cmd_t log_q[$];
  logic [31:0] ph_exp [4] = '{PH_PLUS90, PH_MINUS90, PH_MINUS90, PH_PLUS90};
  logic [31:0] sw_exp [4] = '{SW_NORMAL, SW_NORMAL, SW_REVERSE, SW_REVERSE};
  logic [AW-1:0] rst_a [6] = '{REG_NORMAL_CAL_FACTOR, REG_REVERSE_CAL_FACTOR, REG_READ_TOL,
                               REG_FINAL_TOL, REG_MAX_ITER, 4'hf};
  logic [31:0] rst_v [6] = '{32'h100, 32'h100, 32'h10, 32'h5, 32'h10, 32'h0};
  int num_errors = 0;
  int comparisons = 0;
  int cyc = 0, t_ph = 0, min_gap = 1000000, k = 0, nofs = 0, nconv = 0;

  paz_sequencer #(.SETTLE_CYCLES(SETTLE)) DUT (.core_clk_in(clk),
    .rst_n_in(rst_n), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
    .rd_in(rd), .rdata_out(rdata), .flag_in(flag), .reading_in(reading),
    .sc_pulse_out(sc), .cmd_out(cmd));
  paz_far_model u_far (.clk_in(clk), .rst_n_in(rst_n), .sc_in(sc),
    .cmd_in(cmd), .err_in(err), .glitch_in(glitch), .flag_out(flag),
    .reading_out(reading));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Log commands; shortest gap from a phase to the next conversion
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (sc)
      log_q.push_back(cmd);
    if (sc && cmd.kind == PAZ_CMD_PHASE)
      t_ph <= cyc;
    if (sc && cmd.kind == PAZ_CMD_CONVERT && cyc - t_ph < min_gap)
      min_gap <= cyc - t_ph;
  end

  task automatic check(input string what, input logic [34:0] exp,
                       input logic [34:0] got);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Idle cycle after each strobe so no strobe is assigned twice at once
  task automatic bus_wr(input logic [AW-1:0] a, input logic [31:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : bus_wr

  task automatic bus_rd(input logic [AW-1:0] a);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask : bus_rd

  // Poll status until all bits of the mask are set, bounded
  task automatic wait_st(input logic [3:0] m);
    int n;
    n = 0;
    bus_rd(REG_STATUS);
    while ((d[3:0] & m) !== m && n < 5000)
    begin
      bus_rd(REG_STATUS);
      n++;
    end
  endtask : wait_st

  task automatic tail_chk(input logic [31:0] freq);
    check("restore freq", paz_cmd_t'{PAZ_CMD_FREQ, freq}, log_q[$-2]);
    check("restore switch", paz_cmd_t'{PAZ_CMD_SWITCH, SW_NORMAL}, log_q[$-1]);
    check("restore phase", paz_cmd_t'{PAZ_CMD_PHASE, PH_ZERO}, log_q[$]);
  endtask : tail_chk

  task automatic finish_test;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  // Whole run needs a few thousand cycles
  initial
  begin
    repeat (40000) @(posedge clk);
    num_errors++;
    finish_test;
  end

  initial
  begin
    {rst_n, wr, rd, addr, wdata} = '0;
    err = 16'd107;
    glitch = 1'b1;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 6; i++)
    begin
      bus_rd(rst_a[i]);
      check("reset value", 35'(rst_v[i]), 35'(d));
    end
    // Range offset 5 makes the second pass land exactly on the tolerance
    bus_wr(REG_NORMAL_CAL_FACTOR, 32'h1);
    bus_wr(REG_REVERSE_CAL_FACTOR, 32'h1);
    bus_wr(REG_RANGE_OFS, 32'h5);
    bus_wr(REG_ORIG_FREQ, 32'h3e8);
    bus_wr(REG_ATTEN_CORR, 32'h3);
    bus_wr(REG_FREQ_ADJ, 32'h2);
    bus_wr(REG_CTRL, 32'h1);
    wait_st(4'h2);
    check("status run one", 35'h2, 35'(d[3:0]));
    check("first command", paz_cmd_t'{PAZ_CMD_FREQ, AZ_FREQ_HZ}, log_q[0]);
    foreach (log_q[i])
    begin
      if (log_q[i].kind == PAZ_CMD_SWITCH)
        sw = log_q[i].data;
      if (log_q[i].kind == PAZ_CMD_OFFSET && nofs == 0)
        check("pass offset", 35'd112, 35'(log_q[i].data));
      if (log_q[i].kind == PAZ_CMD_OFFSET)
        nofs++;
      if (log_q[i].kind == PAZ_CMD_CONVERT)
        nconv++;
      if (log_q[i].kind == PAZ_CMD_PHASE && k < 4)
      begin
        check("cond phase", 35'(ph_exp[k]), 35'(log_q[i].data));
        check("cond switch", 35'(sw_exp[k]), 35'(sw));
        k++;
      end
    end
    check("offset count", 35'd4, 35'(nofs));
    check("retake seen", 35'd1, 35'(nconv > 48));
    check("settle gap", 35'd1, 35'(min_gap >= SETTLE));
    check("final offset", paz_cmd_t'{PAZ_CMD_OFFSET, 32'd112}, log_q[$-3]);
    tail_chk(32'h3e8);
    // Unequal factors: swap, ask for new ones once, then hit the pass limit
    log_q.delete();
    err <= 16'd1000;
    bus_wr(REG_NORMAL_CAL_FACTOR, 32'h1);
    bus_wr(REG_REVERSE_CAL_FACTOR, 32'h4);
    bus_wr(REG_MAX_ITER, 32'h1);
    bus_wr(REG_ORIG_FREQ, 32'h7d0);
    bus_wr(REG_CTRL, 32'h1);
    wait_st(4'h8);
    check("cal request", 35'h9, 35'(d[3:0]));
    bus_rd(REG_NORMAL_CAL_FACTOR);
    check("larger factor", 35'h4, 35'(d));
    // Still over 25 percent apart: no second request, factor 2 is used
    bus_wr(REG_NORMAL_CAL_FACTOR, 32'h1);
    bus_wr(REG_REVERSE_CAL_FACTOR, 32'h2);
    bus_wr(REG_CTRL, 32'h2);
    wait_st(4'h2);
    check("status abort", 35'h6, 35'(d[3:0]));
    check("scaled offset", paz_cmd_t'{PAZ_CMD_OFFSET, 32'd449},
          log_q[$-3]);
    tail_chk(32'h7d0);
    bus_rd(REG_CORR_ACC);
    check("accumulator", 35'd444, 35'(d));
    bus_rd(REG_ITER);
    check("pass count", 35'h1, 35'(d));
    finish_test;
  end
endmodule : tb_paz_sequencer
`default_nettype wire
